// ---- core/seq_volt_pkg.sv ----
package seq_volt_pkg;

  // ------------------------------------------------------------
  // data widths
  // ------------------------------------------------------------
  localparam int PH_W = 18;          // signed phasor component width
  localparam int MAG_W = 18;         // unsigned magnitude width, nominal scaled
  localparam int SET_W = 15;         // setting in 0.01 % steps of nominal

  // ------------------------------------------------------------
  // magnitude scaling: nominal voltage equals this code
  // ------------------------------------------------------------
  localparam logic [MAG_W-1:0] NOMINAL_CODE = 18'h02710;  // 10000 = 100.00 %

  // ------------------------------------------------------------
  // setting limits and defaults, 0.01 % units
  // ------------------------------------------------------------
  localparam logic [SET_W-1:0] PICKUP_MIN = 15'h01F4;     // 5.00 %
  localparam logic [SET_W-1:0] PICKUP_MAX = 15'h3A98;     // 150.00 %
  localparam logic [SET_W-1:0] PICKUP_DEF = 15'h2904;     // 105.00 %
  localparam logic [SET_W-1:0] BLOCK_MAX = 15'h1F40;      // 80.00 %
  localparam logic [SET_W-1:0] BLOCK_DEF = 15'h01F4;      // 5.00 %

  // ------------------------------------------------------------
  // hysteresis ratios in percent
  // ------------------------------------------------------------
  localparam logic [7:0] RELEASE_OVER_PCT = 8'h61;        // 97 %
  localparam logic [7:0] RELEASE_UNDER_PCT = 8'h67;       // 103 %
  localparam logic [7:0] PCT_FULL = 8'h64;                // 100 %

  // ------------------------------------------------------------
  // rotation and scaling constants, Q1.16: cos/sin of 120 degrees, one third
  // ------------------------------------------------------------
  localparam logic signed [17:0] COS120_Q = -18'sh08000;  // -0.5
  localparam logic signed [17:0] SIN120_Q = 18'sh0DDB4;   // +0.866025
  localparam logic signed [17:0] THIRD_Q = 18'sh05555;    // 1/3
  localparam int Q_SHIFT = 16;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'h0,
    FORCE_START = 2'h1,
    FORCE_TRIP = 2'h2,
    FORCE_BLOCKED = 2'h3
  } forced_stage_status_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_BLOCKED = 2'h3
  } stage_state_e;

  // ------------------------------------------------------------
  // pipeline latency of the sequence calculator
  // ------------------------------------------------------------
  localparam int SEQ_LATENCY = 3;

endpackage

// ---- core/seq_component_calc.sv ----
`timescale 1ns/1ns
module seq_component_calc
  import seq_volt_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // phasor input, real and imaginary per phase
  input wire logic valid_in,
  input wire logic signed [seq_volt_pkg::PH_W-1:0] re_in [3],
  input wire logic signed [seq_volt_pkg::PH_W-1:0] im_in [3],
  input wire logic negative_in,
  // sequence phasor output
  output logic valid_out,
  output logic signed [seq_volt_pkg::PH_W-1:0] seq_re_out,
  output logic signed [seq_volt_pkg::PH_W-1:0] seq_im_out
);
  import seq_volt_pkg::*;

  // ------------------------------------------------------------
  // rotation of phases two and three
  // ------------------------------------------------------------
  // rotation by +120 is (c, s); by +240 is (c, -s)
  logic signed [17:0] sin2;                // sine used for phase two
  logic signed [17:0] sin3;                // sine used for phase three
  assign sin2 = negative_in ? -SIN120_Q : SIN120_Q;
  assign sin3 = negative_in ? SIN120_Q : -SIN120_Q;

  logic signed [PH_W+18:0] r2_re, r2_im, r3_re, r3_im;  // rotated products
  assign r2_re = re_in[1] * COS120_Q - im_in[1] * sin2;
  assign r2_im = re_in[1] * sin2 + im_in[1] * COS120_Q;
  assign r3_re = re_in[2] * COS120_Q - im_in[2] * sin3;
  assign r3_im = re_in[2] * sin3 + im_in[2] * COS120_Q;

  // ------------------------------------------------------------
  // stage 1: rotated phases, stage 2: sum, stage 3: divide by three
  // ------------------------------------------------------------
  logic signed [PH_W+1:0] s1_re [3];       // registered phase terms
  logic signed [PH_W+1:0] s1_im [3];
  logic signed [PH_W+2:0] s2_re, s2_im;    // sum of three
  logic signed [PH_W+20:0] p3_re, p3_im;   // product with one third
  logic [1:0] vpipe;                       // valid shift register

  assign p3_re = s2_re * THIRD_Q;
  assign p3_im = s2_im * THIRD_Q;

  // pipelined so the multipliers stay off one long path
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int k = 0; k < 3; k++) begin
        s1_re[k] <= '0;
        s1_im[k] <= '0;
      end
      s2_re <= '0;
      s2_im <= '0;
      seq_re_out <= '0;
      seq_im_out <= '0;
      vpipe <= 2'h0;
      valid_out <= 1'b0;
    end else begin
      s1_re[0] <= (PH_W+2)'(re_in[0]);
      s1_im[0] <= (PH_W+2)'(im_in[0]);
      s1_re[1] <= (PH_W+2)'(r2_re >>> Q_SHIFT);
      s1_im[1] <= (PH_W+2)'(r2_im >>> Q_SHIFT);
      s1_re[2] <= (PH_W+2)'(r3_re >>> Q_SHIFT);
      s1_im[2] <= (PH_W+2)'(r3_im >>> Q_SHIFT);
      s2_re <= (PH_W+3)'(s1_re[0] + s1_re[1] + s1_re[2]);
      s2_im <= (PH_W+3)'(s1_im[0] + s1_im[1] + s1_im[2]);
      seq_re_out <= PH_W'(p3_re >>> Q_SHIFT);
      seq_im_out <= PH_W'(p3_im >>> Q_SHIFT);
      vpipe <= {vpipe[0], valid_in};
      valid_out <= vpipe[1];
    end
  end

endmodule

// ---- core/magnitude_est.sv ----
`timescale 1ns/1ns
module magnitude_est
  import seq_volt_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // phasor in
  input wire logic valid_in,
  input wire logic signed [seq_volt_pkg::PH_W-1:0] re_in,
  input wire logic signed [seq_volt_pkg::PH_W-1:0] im_in,
  // magnitude out
  output logic valid_out,
  output logic [seq_volt_pkg::MAG_W-1:0] mag_out
);
  import seq_volt_pkg::*;

  // ------------------------------------------------------------
  // alpha-max-beta-min estimate: max + 3/8 min
  // ------------------------------------------------------------
  // trade-off: about 7 % worst error, no square root needed
  logic [PH_W-1:0] abs_re, abs_im;   // absolute components
  logic [PH_W-1:0] big, minor;       // ordered components
  logic [PH_W+1:0] est;              // estimate before clamp
  assign abs_re = re_in[PH_W-1] ? PH_W'(-re_in) : PH_W'(re_in);
  assign abs_im = im_in[PH_W-1] ? PH_W'(-im_in) : PH_W'(im_in);
  assign big = (abs_re > abs_im) ? abs_re : abs_im;
  assign minor = (abs_re > abs_im) ? abs_im : abs_re;
  assign est = (PH_W+2)'(big) + (PH_W+2)'((minor * 3) >> 3);

  // registered magnitude, saturating at full scale
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mag_out <= '0;
      valid_out <= 1'b0;
    end else begin
      mag_out <= (|est[PH_W+1:MAG_W]) ? '1 : est[MAG_W-1:0];
      valid_out <= valid_in;
    end
  end

endmodule

// ---- core/seq_volt_stage.sv ----
`timescale 1ns/1ns
// Behaviour
// - positive sequence: L1 + aL2 + a2L3, thirds
// - negative sequence: L1 + a2L2 + aL3, thirds
// - uses fundamental phasors of voltage channels
// - static select positive or negative, default positive
// - forced status normal/start/trip/blocked when enabled
// - direction over or under, default over
// - pickup 5.00..150.00 percent, default 105
// - over: release below 97 percent
// - under: release above 103 percent
// - ratio recomputed every evaluation
// - pickup on threshold crossing in direction
// - threshold and block level change live
// - select and forced status static, forcing enable live; not group switched
// - under block level 0..80 percent, default 5
// - below block level suppress trip
// - block latched until all lines exceed pickup
// - block level zero disables blocking
// - external block at pickup gives blocked
// - zero delay: trip together with start
module seq_volt_stage
  import seq_volt_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // phasor inputs from measurement front end
  input wire logic phasor_valid_in,
  input wire logic signed [seq_volt_pkg::PH_W-1:0] phase_re_in [3],
  input wire logic signed [seq_volt_pkg::PH_W-1:0] phase_im_in [3],
  input wire logic [seq_volt_pkg::MAG_W-1:0] line_mag_in [3],
  // general settings: select and forced status static, forcing enable live
  input wire logic select_negative_in,
  input wire logic forcing_enable_in,
  input wire logic [1:0] forced_stage_status_in,
  // group settings, live
  input wire logic under_direction_in,
  input wire logic [seq_volt_pkg::SET_W-1:0] pickup_threshold_in,
  input wire logic [seq_volt_pkg::SET_W-1:0] under_block_level_in,
  input wire logic fixed_delay_zero_in,
  // external block from blocking matrix
  input wire logic ext_block_in,
  // status outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic pickup_out,
  output logic under_blocking_out,
  output logic [seq_volt_pkg::MAG_W-1:0] supervised_magnitude_out,
  output logic [15:0] ratio_out,
  output logic eval_out
);
  import seq_volt_pkg::*;

  // ------------------------------------------------------------
  // static settings captured at reset release
  // ------------------------------------------------------------
  // select and forced status stay put; a group switch cannot reach them
  logic sel_negative;                  // captured magnitude select
  logic [1:0] force_sel;               // captured forced status
  logic captured;                      // capture done flag

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_negative <= 1'b0;            // positive by default
      force_sel <= FORCE_NORMAL;       // normal by default
      captured <= 1'b0;
    end else if (!captured) begin
      sel_negative <= select_negative_in;
      force_sel <= forced_stage_status_in;
      captured <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // sequence calculation and magnitude
  // ------------------------------------------------------------
  // front end qualifies each phasor set with a strobe
  logic seq_valid;                     // sequence phasor ready
  logic signed [PH_W-1:0] seq_re, seq_im;  // sequence phasor
  logic mag_valid;                     // magnitude ready
  logic [MAG_W-1:0] mag;               // supervised magnitude

  seq_component_calc u_seq (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .valid_in(phasor_valid_in),
    .re_in(phase_re_in),
    .im_in(phase_im_in),
    .negative_in(sel_negative),
    .valid_out(seq_valid),
    .seq_re_out(seq_re),
    .seq_im_out(seq_im)
  );

  magnitude_est u_mag (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .valid_in(seq_valid),
    .re_in(seq_re),
    .im_in(seq_im),
    .valid_out(mag_valid),
    .mag_out(mag)
  );

  // ------------------------------------------------------------
  // setting clamps, live group values
  // ------------------------------------------------------------
  logic [SET_W-1:0] pick_set;          // clamped pickup setting
  logic [SET_W-1:0] blk_set;           // clamped block setting
  assign pick_set = (pickup_threshold_in < PICKUP_MIN) ? PICKUP_MIN :
                    (pickup_threshold_in > PICKUP_MAX) ? PICKUP_MAX :
                    pickup_threshold_in;
  assign blk_set = (under_block_level_in > BLOCK_MAX) ? BLOCK_MAX :
                   under_block_level_in;

  // ------------------------------------------------------------
  // comparison levels, scaled by 100 to avoid division
  // ------------------------------------------------------------
  // magnitude code is 0.01 % units of nominal, same as settings
  logic [MAG_W+7:0] mag_x100;          // magnitude times 100
  logic [MAG_W+7:0] pick_x100;         // pickup times 100
  logic [MAG_W+7:0] rel_over;          // pickup times 97
  logic [MAG_W+7:0] rel_under;         // pickup times 103
  assign mag_x100 = (MAG_W+8)'(mag) * (MAG_W+8)'(PCT_FULL);
  assign pick_x100 = (MAG_W+8)'(pick_set) * (MAG_W+8)'(PCT_FULL);
  assign rel_over = (MAG_W+8)'(pick_set) * (MAG_W+8)'(RELEASE_OVER_PCT);
  assign rel_under = (MAG_W+8)'(pick_set) * (MAG_W+8)'(RELEASE_UNDER_PCT);

  logic over_pick, over_hold;          // over direction terms
  logic under_pick, under_hold;        // under direction terms
  assign over_pick = mag_x100 > pick_x100;
  assign over_hold = mag_x100 >= rel_over;
  assign under_pick = mag_x100 < pick_x100;
  assign under_hold = mag_x100 <= rel_under;

  // ------------------------------------------------------------
  // pickup element with hysteresis
  // ------------------------------------------------------------
  logic pickup;                        // pickup element state
  logic next_pickup;                   // next pickup value
  assign next_pickup = under_direction_in ?
                       (pickup ? under_hold : under_pick) :
                       (pickup ? over_hold : over_pick);

  // evaluated once per phasor set, never paused
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pickup <= 1'b0;
    end else if (mag_valid) begin
      pickup <= next_pickup;
    end
  end

  // ------------------------------------------------------------
  // ratio of supervised magnitude to pickup, 0.01 units
  // ------------------------------------------------------------
  // iterative divider: one quotient bit per clock, far inside a cycle
  logic [4:0] div_cnt;                 // remaining quotient bits
  logic [MAG_W+7:0] div_rem;           // running remainder
  logic [15:0] div_q;                  // quotient build
  logic [SET_W-1:0] div_den;           // held denominator
  logic [MAG_W+8:0] trial;             // trial remainder
  assign trial = {div_rem, div_q[15]} ;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt <= 5'h00;
      div_rem <= '0;
      div_q <= 16'h0000;
      div_den <= '0;
      ratio_out <= 16'h0000;
    end else if (mag_valid) begin
      div_cnt <= 5'h10;                // restart on every evaluation
      div_rem <= (MAG_W+8)'(mag_x100 >> 16);  // high part, always below pickup
      div_q <= 16'(mag_x100);
      div_den <= pick_set;
    end else if (div_cnt != 5'h00) begin
      if (trial >= (MAG_W+9)'(div_den)) begin
        div_rem <= (MAG_W+8)'(trial - (MAG_W+9)'(div_den));
        div_q <= {div_q[14:0], 1'b1};
      end else begin
        div_rem <= (MAG_W+8)'(trial);
        div_q <= {div_q[14:0], 1'b0};
      end
      div_cnt <= div_cnt - 5'h01;
      if (div_cnt == 5'h01) begin
        ratio_out <= (trial >= (MAG_W+9)'(div_den)) ?
                     {div_q[14:0], 1'b1} : {div_q[14:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // undervoltage blocking latch
  // ------------------------------------------------------------
  logic blk_en;                        // block level in use
  logic below_blk;                     // measured under block level
  logic all_above;                     // every line above pickup
  logic under_blk;                     // latched blocking
  logic [2:0] line_above;              // per line comparison
  assign blk_en = under_direction_in && (blk_set != '0);
  assign below_blk = mag < MAG_W'(blk_set);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_line
      assign line_above[g] = line_mag_in[g] > MAG_W'(pick_set);
    end
  endgenerate
  assign all_above = &line_above;

  // set wins over the release in the same evaluation
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      under_blk <= 1'b0;
    end else if (!blk_en) begin
      under_blk <= 1'b0;
    end else if (mag_valid) begin
      if (below_blk) begin
        under_blk <= 1'b1;
      end else if (all_above) begin
        under_blk <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // stage state: start or blocked decided at pickup edge
  // ------------------------------------------------------------
  stage_state_e state, next_state;     // stage state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (pickup) begin
          next_state = ext_block_in ? ST_BLOCKED : ST_START;
        end
      end
      ST_START: begin
        if (!pickup || ext_block_in) begin
          next_state = ST_IDLE;        // start resets on later block
        end
      end
      ST_BLOCKED: begin
        if (!pickup) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // outputs, forcing overrides natural status
  // ------------------------------------------------------------
  // only the zero-delay case is built here; timed trips lie elsewhere
  logic nat_start, nat_trip, nat_blocked;  // natural status
  assign nat_start = (state == ST_START);
  assign nat_trip = nat_start && fixed_delay_zero_in && !under_blk;
  assign nat_blocked = (state == ST_BLOCKED);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else if (forcing_enable_in) begin
      start_out <= (force_sel == FORCE_START);
      trip_out <= (force_sel == FORCE_TRIP);
      blocked_out <= (force_sel == FORCE_BLOCKED);
    end else begin
      start_out <= nat_start;
      trip_out <= nat_trip;
      blocked_out <= nat_blocked;
    end
  end

  // monitored values for the info view
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      supervised_magnitude_out <= '0;
      eval_out <= 1'b0;
    end else begin
      if (mag_valid) begin
        supervised_magnitude_out <= mag;
      end
      eval_out <= mag_valid;
    end
  end

  assign pickup_out = pickup;
  assign under_blocking_out = under_blk;

endmodule

// ---- bench/seq_volt_props.sv ----
`timescale 1ns/1ns
module seq_volt_props
  import seq_volt_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // watched inputs
  input wire logic phasor_valid_in,
  input wire logic forcing_enable_in,
  input wire logic under_direction_in,
  input wire logic [seq_volt_pkg::SET_W-1:0] pickup_threshold_in,
  input wire logic [seq_volt_pkg::SET_W-1:0] under_block_level_in,
  input wire logic fixed_delay_zero_in,
  input wire logic ext_block_in,
  // watched outputs
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic pickup_out,
  input wire logic under_blocking_out,
  input wire logic eval_out,
  input wire logic [seq_volt_pkg::MAG_W-1:0] supervised_magnitude_out
);
  // ------------------------------------------------------------
  // scaled terms, widened so the percent products cannot wrap
  // ------------------------------------------------------------
  wire [31:0] mag_x100 = 32'(supervised_magnitude_out) * 32'(PCT_FULL);
  wire [31:0] set_x100 = 32'(pickup_threshold_in) * 32'(PCT_FULL);
  wire [31:0] set_x97 = 32'(pickup_threshold_in) * 32'(RELEASE_OVER_PCT);
  wire [31:0] set_x103 = 32'(pickup_threshold_in) * 32'(RELEASE_UNDER_PCT);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_eval_follows_valid: assert property (phasor_valid_in |-> ##[5:6] eval_out)
    else $error("evaluation pulse missing after phasor set");
  a_over_band: assert property (eval_out && !under_direction_in && !forcing_enable_in |->
    pickup_out == (mag_x100 > set_x100 || ($past(pickup_out) && mag_x100 >= set_x97)))
    else $error("over pickup band wrong");
  a_under_band: assert property (eval_out && under_direction_in && !forcing_enable_in |->
    pickup_out == (mag_x100 < set_x100 || ($past(pickup_out) && mag_x100 <= set_x103)))
    else $error("under pickup band wrong");
  a_start_on_pickup: assert property ($rose(pickup_out) ##0
    (pickup_out && !ext_block_in && !forcing_enable_in)[*3] |-> start_out && !blocked_out)
    else $error("start missing after pickup");
  a_blocked_on_ext: assert property ($rose(pickup_out) ##0
    (pickup_out && ext_block_in && !forcing_enable_in)[*3] |-> blocked_out && !start_out)
    else $error("blocked missing under external block");
  a_trip_zero_delay: assert property ($rose(start_out) && fixed_delay_zero_in &&
    !under_blocking_out && !forcing_enable_in |-> trip_out)
    else $error("trip not with start at zero delay");
  a_no_trip_latched: assert property ((under_blocking_out && !forcing_enable_in)[*3] |-> !trip_out)
    else $error("trip while under block latched");
  a_over_no_latch: assert property ((!under_direction_in)[*2] |-> !under_blocking_out)
    else $error("under block latched in over direction");
  a_zero_level_off: assert property ((under_block_level_in == '0)[*2] |-> !under_blocking_out)
    else $error("under block latched with zero level");

  // main scenarios reached
  cover property ($rose(start_out));
  cover property ($rose(blocked_out));
  cover property ($rose(under_blocking_out));
endmodule

bind seq_volt_stage seq_volt_props seq_volt_props_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .phasor_valid_in(phasor_valid_in), .forcing_enable_in(forcing_enable_in),
  .under_direction_in(under_direction_in), .pickup_threshold_in(pickup_threshold_in),
  .under_block_level_in(under_block_level_in), .fixed_delay_zero_in(fixed_delay_zero_in),
  .ext_block_in(ext_block_in), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
  .pickup_out(pickup_out), .under_blocking_out(under_blocking_out), .eval_out(eval_out),
  .supervised_magnitude_out(supervised_magnitude_out));

// ---- bench/front_end_model.sv ----
`timescale 1ns/1ns
module front_end_model
  import seq_volt_pkg::*;
(
  // clock
  input wire logic mclk_in,
  // phasor set towards the stage
  output logic phasor_valid_out,
  output logic signed [seq_volt_pkg::PH_W-1:0] phase_re_out [3],
  output logic signed [seq_volt_pkg::PH_W-1:0] phase_im_out [3],
  output logic [seq_volt_pkg::MAG_W-1:0] line_mag_out [3]
);
  import seq_volt_pkg::*;
  // idle state: no strobe, lines at zero
  initial begin
    phasor_valid_out = 1'b0;
    phase_re_out = '{default: '1};
    phase_im_out = '{default: '1};
    line_mag_out = '{default: '0};
  end
  // line magnitudes are levels, held until changed
  task automatic set_lines(input int v);
    line_mag_out = '{default: MAG_W'(v)};
  endtask
  // balanced set, reversed rotation when neg; one strobe per set
  task automatic send(input int amp, input bit neg, input int gap);
    int s;
    s = (amp * 866) / 1000;
    @(negedge mclk_in);
    phasor_valid_out = 1'b1;
    phase_re_out = '{PH_W'(amp), PH_W'(-amp / 2), PH_W'(-amp / 2)};
    phase_im_out = '{'0, PH_W'(neg ? s : -s), PH_W'(neg ? -s : s)};
    @(negedge mclk_in);
    phasor_valid_out = 1'b0;
    // released values inverted so a late sample cannot pass by luck
    for (int k = 0; k < 3; k++) begin
      phase_re_out[k] = ~phase_re_out[k];
      phase_im_out[k] = ~phase_im_out[k];
    end
    repeat (gap) @(negedge mclk_in);
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb;
  import seq_volt_pkg::*;
  // stimulus, all changed at the falling edge
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sel_neg = 1'b0;
  logic force_en = 1'b0;
  logic [1:0] force_st = 2'h0;
  logic under_dir = 1'b0;
  logic [SET_W-1:0] pickup = PICKUP_DEF;
  logic [SET_W-1:0] blk_lvl = BLOCK_DEF;
  logic delay_zero = 1'b1;
  logic ext_blk = 1'b0;
  // front end and status wires
  logic ph_valid;
  logic signed [PH_W-1:0] ph_re [3];
  logic signed [PH_W-1:0] ph_im [3];
  logic [MAG_W-1:0] line_mag [3];
  logic start, trip, blocked, pick, under_block_level, ev;
  logic [MAG_W-1:0] mag;
  logic [15:0] ratio;
  int failures = 0;
  int n_compared = 0;

  always #5 mclk_in = ~mclk_in;

  front_end_model front_end_model_i (.mclk_in(mclk_in), .phasor_valid_out(ph_valid), .phase_re_out(ph_re),
    .phase_im_out(ph_im), .line_mag_out(line_mag));
  seq_volt_stage seq_volt_stage_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .phasor_valid_in(ph_valid),
    .phase_re_in(ph_re), .phase_im_in(ph_im), .line_mag_in(line_mag), .select_negative_in(sel_neg),
    .forcing_enable_in(force_en), .forced_stage_status_in(force_st), .under_direction_in(under_dir),
    .pickup_threshold_in(pickup), .under_block_level_in(blk_lvl), .fixed_delay_zero_in(delay_zero),
    .ext_block_in(ext_blk), .start_out(start), .trip_out(trip), .blocked_out(blocked), .pickup_out(pick),
    .under_blocking_out(under_block_level), .supervised_magnitude_out(mag), .ratio_out(ratio), .eval_out(ev));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // static settings are only taken at release, so apply them first
  task automatic do_reset(input logic neg, input logic [1:0] fst);
    @(negedge mclk_in);
    rstn_in = 1'b0;
    sel_neg = neg;
    force_st = fst;
    repeat (12) @(negedge mclk_in);
    rstn_in = 1'b1;
    repeat (2) @(negedge mclk_in);
  endtask
  // one set, then the settled bits {pickup,start,trip,blocked,latch}
  task automatic send_chk(input int amp, input bit neg, input logic [4:0] exp);
    front_end_model_i.send(amp, neg, 25);
    chk("status", {pick, start, trip, blocked, under_block_level}, exp);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_over();
    under_dir = 1'b0;
    send_chk(18'h02AF8, 1'b0, 5'h1C);
    chk("ratio", ratio >= 16'h0067 && ratio <= 16'h006A, 32'h1);
    chk("magnitude", mag >= 18'h02AF0 && mag <= 18'h02AF8, 32'h1);
    send_chk(18'h0283C, 1'b0, 5'h1C);
    send_chk(18'h02774, 1'b0, 5'h00);
    send_chk(18'h02AF8, 1'b1, 5'h00);
    delay_zero = 1'b0;
    send_chk(18'h02AF8, 1'b0, 5'h18);
    delay_zero = 1'b1;
    pickup = 15'h2EE0;
    send_chk(18'h02AF8, 1'b0, 5'h00);
    pickup = PICKUP_DEF;
  endtask
  task automatic t_under();
    under_dir = 1'b1;
    blk_lvl = BLOCK_DEF; // nonzero level until the zero-level check
    pickup = 15'h2328;
    front_end_model_i.set_lines(9500);
    send_chk(18'h02134, 1'b0, 5'h1C);
    send_chk(18'h023F0, 1'b0, 5'h1C);
    send_chk(18'h024B8, 1'b0, 5'h00);
    // dead network: latch engages and holds until all lines recover
    front_end_model_i.set_lines(300);
    send_chk(18'h0012C, 1'b0, 5'h19);
    send_chk(18'h0251C, 1'b0, 5'h01);
    front_end_model_i.set_lines(9500);
    send_chk(18'h0251C, 1'b0, 5'h00);
    blk_lvl = 15'h0000;
    send_chk(18'h0012C, 1'b0, 5'h1C);
    blk_lvl = BLOCK_DEF;
    pickup = PICKUP_DEF;
    under_dir = 1'b0;
    send_chk(18'h024B8, 1'b0, 5'h00);
  endtask
  task automatic t_ext();
    ext_blk = 1'b1;
    send_chk(18'h02AF8, 1'b0, 5'h12);
    ext_blk = 1'b0;
    send_chk(18'h02710, 1'b0, 5'h00);
  endtask
  task automatic t_select();
    do_reset(1'b1, FORCE_NORMAL);
    send_chk(18'h02AF8, 1'b1, 5'h1C);
    send_chk(18'h02AF8, 1'b0, 5'h00);
    sel_neg = 1'b0;
    send_chk(18'h02AF8, 1'b1, 5'h1C);
    do_reset(1'b0, FORCE_NORMAL);
  endtask
  task automatic t_force();
    logic [2:0] want [4];
    want = '{3'h0, 3'h4, 3'h2, 3'h1};
    force_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      do_reset(1'b0, 2'(k));
      repeat (4) @(negedge mclk_in);
      chk("forced", {start, trip, blocked}, want[k]);
    end
    force_en = 1'b0;
    do_reset(1'b0, FORCE_NORMAL);
  endtask

  // main sequence
  initial begin
    do_reset(1'b0, FORCE_NORMAL);
    t_over();
    t_under();
    t_ext();
    t_select();
    t_force();
    end_sim();
  end
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
